//--- cct_chan_cmp.sv
`default_nettype none
module cct_chan_cmp (
  cct_chan_if.cmp ch
);
  logic [15:0] drop;
  logic [15:0] rise;
  logic [15:0] delta;
  always_comb begin
    drop = (ch.avg > ch.cnt) ? ch.avg - ch.cnt : 16'h0000;
    rise = (ch.cnt > ch.avg) ? ch.cnt - ch.avg : 16'h0000;
    // one-sided detection only looks at counts falling below average
    delta = (ch.bidir && rise > drop) ? rise : drop;
    ch.near_hit = delta > {8'h00, ch.near_thr};
    ch.cont_hit = delta > {8'h00, ch.cont_thr};
  end
endmodule
`default_nettype wire

//--- cct_chan_if.sv
`default_nettype none
interface cct_chan_if;
  logic [7:0]  near_thr;
  logic [7:0]  cont_thr;
  logic        bidir;
  logic [15:0] avg;
  logic [15:0] cnt;
  logic        near_hit;
  logic        cont_hit;
  modport ctl (output near_thr, cont_thr, bidir, avg, cnt,
               input near_hit, cont_hit);
  modport cmp (input near_thr, cont_thr, bidir, avg, cnt,
               output near_hit, cont_hit);
endinterface
`default_nettype wire

//--- cct_host.sv
`default_nettype none
module cct_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output var  logic       wr_o,
  output var  logic       rd_o,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // bus cycles; idle lines show the inverse, except wdata_o, which a read leaves as it was
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(posedge clk_i) #1;
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge clk_i) #1;
    {rd_o, addr_o} = {1'b1, a};
    @(posedge clk_i) #1;
    {rd_o, addr_o} = {1'b0, ~a};
    // valid stands one cycle, so it is sampled right here
    ok = rvalid_i;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

//--- cct_pkg.sv
`default_nettype none
package cct_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_FLAGS      = 8'h11;
  localparam logic [7:0] ADDR_TUNE0      = 8'h43;
  localparam logic [7:0] ADDR_TUNE1      = 8'h44;
  localparam logic [7:0] ADDR_FILT       = 8'h45;
  localparam logic [7:0] ADDR_COMP0      = 8'h46;
  localparam logic [7:0] ADDR_COMP1      = 8'h47;
  localparam logic [7:0] ADDR_GAIN0      = 8'h48;
  localparam logic [7:0] ADDR_GAIN1      = 8'h49;
  localparam logic [7:0] ADDR_NEAR0      = 8'h50;
  localparam logic [7:0] ADDR_CONT0      = 8'h51;
  localparam logic [7:0] ADDR_NEAR1      = 8'h52;
  localparam logic [7:0] ADDR_CONT1      = 8'h53;
  localparam logic [7:0] ADDR_PAUSE      = 8'h54;
  // ==========================================================
  // reset values and filter write mask
  localparam logic [7:0] RST_TUNE        = 8'h50;
  localparam logic [7:0] RST_FILT        = 8'h00;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_PAUSE       = 8'h28;
  localparam logic [7:0] FILT_MASK       = 8'h6f;
  // ==========================================================
  // field positions
  localparam int BASE_LSB   = 6;
  localparam int TARGET_MSB = 5;
  localparam int DIV_BIT    = 6;
  localparam int BIDIR_BIT  = 5;
  localparam int LTA_LSB    = 2;
  localparam int COMPH_LSB  = 6;
  localparam int COARSE_LSB = 4;
  localparam int FLAG_NEAR0 = 0;
  localparam int FLAG_NEAR1 = 1;
  localparam int FLAG_CONT0 = 4;
  localparam int FLAG_CONT1 = 5;
  // ==========================================================
  // decoded values
  localparam logic [7:0] BASE_00 = 8'h4b;
  localparam logic [7:0] BASE_01 = 8'h64;
  localparam logic [7:0] BASE_10 = 8'h96;
  localparam logic [7:0] BASE_11 = 8'hc8;
  localparam logic [3:0] LTA_MIN = 4'h7;
  localparam logic [2:0] ACF_MIN = 3'h1;
  localparam int         TARGET_SHIFT = 5;
  // ==========================================================
  // timing
  localparam int CLK_HZ        = 250_000_000;
  localparam int PAUSE_TICK_MS = 500;
  localparam int PAUSE_TICK_CYC = CLK_HZ / 1000 * PAUSE_TICK_MS;
endpackage
`default_nettype wire

//--- cct_regs.sv
// Contract
// - tuning bits 7-6 pick base 75, 100, 150 or 200.
// - tuning bits 5-0 times thirty-two give the tuning target.
// - filter bit 6 enables the sampling capacitor divider.
// - filter bit 5 enables detection of deltas in both directions.
// - filter bits 3-2 pick long average weight 7 to 10.
// - compensation low bytes at 0x46 and 0x47.
// - gain bits 7-6 are compensation bits 9-8, forming ten bits.
// - gain bits 5-4 are the coarse multiplier.
// - gain bits 3-0 are the fine multiplier.
// - gain registers at 0x48 and 0x49.
// - flag event when average minus count exceeds the threshold.
// - thresholds at 0x50 to 0x53, near then contact per channel.
// - pause period counts 500 ms ticks, default 0x28 is 20 s.
// - flags at 0x11: bits 0,1 near, bits 4,5 contact.
`default_nettype none
module cct_regs #(
  parameter int PAUSE_TICK_CYC = cct_pkg::PAUSE_TICK_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  output var  logic [7:0]  rdata_o,
  output var  logic        rvalid_o,
  input  wire logic [15:0] chan0_avg_i,
  input  wire logic [15:0] chan0_cnt_i,
  input  wire logic [15:0] chan1_avg_i,
  input  wire logic [15:0] chan1_cnt_i,
  input  wire logic        pause_start_i,
  output var  logic [7:0]  chan0_tuning_base_select_o,
  output var  logic [10:0] chan0_tuning_target_value_o,
  output var  logic [7:0]  chan1_tuning_base_select_o,
  output var  logic [10:0] chan1_tuning_target_value_o,
  output var  logic        cap_divider_en_o,
  output var  logic        bidir_en_o,
  output var  logic [3:0]  long_average_weight_o,
  output var  logic [2:0]  ac_filter_weight_o,
  output var  logic [9:0]  chan0_comp_o,
  output var  logic [9:0]  chan1_comp_o,
  output var  logic [1:0]  chan0_coarse_o,
  output var  logic [3:0]  chan0_fine_o,
  output var  logic [1:0]  chan1_coarse_o,
  output var  logic [3:0]  chan1_fine_o,
  output var  logic [5:0]  flags_o,
  output var  logic        pause_active_o
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]  tune0;
    logic [7:0]  tune1;
    logic [7:0]  filt;
    logic [7:0]  comp0;
    logic [7:0]  comp1;
    logic [7:0]  gain0;
    logic [7:0]  gain1;
    logic [7:0]  near0;
    logic [7:0]  cont0;
    logic [7:0]  near1;
    logic [7:0]  cont1;
    logic [7:0]  pause;
    logic [7:0]  flags;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [31:0] tick_cnt;
    logic [7:0]  pause_left;
  } cct_state_type;

  cct_state_type st_r;
  cct_state_type st_nxt;

  cct_chan_if ch0 ();
  cct_chan_if ch1 ();

  assign ch0.near_thr = st_r.near0;
  assign ch0.cont_thr = st_r.cont0;
  assign ch0.bidir    = st_r.filt[cct_pkg::BIDIR_BIT];
  assign ch0.avg      = chan0_avg_i;
  assign ch0.cnt      = chan0_cnt_i;
  assign ch1.near_thr = st_r.near1;
  assign ch1.cont_thr = st_r.cont1;
  assign ch1.bidir    = st_r.filt[cct_pkg::BIDIR_BIT];
  assign ch1.avg      = chan1_avg_i;
  assign ch1.cnt      = chan1_cnt_i;

  cct_chan_cmp u_cmp0 (
    .ch (ch0)
  );
  cct_chan_cmp u_cmp1 (
    .ch (ch1)
  );

  function automatic logic [7:0] base_of(input logic [1:0] code);
    unique case (code)
      2'b00: base_of = cct_pkg::BASE_00;
      2'b01: base_of = cct_pkg::BASE_01;
      2'b10: base_of = cct_pkg::BASE_10;
      2'b11: base_of = cct_pkg::BASE_11;
    endcase
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (wr_en_i) begin
      unique case (addr_i)
        cct_pkg::ADDR_TUNE0: st_nxt.tune0 = wdata_i;
        cct_pkg::ADDR_TUNE1: st_nxt.tune1 = wdata_i;
        cct_pkg::ADDR_FILT:  st_nxt.filt = wdata_i & cct_pkg::FILT_MASK;
        cct_pkg::ADDR_COMP0: st_nxt.comp0 = wdata_i;
        cct_pkg::ADDR_COMP1: st_nxt.comp1 = wdata_i;
        cct_pkg::ADDR_GAIN0: st_nxt.gain0 = wdata_i;
        cct_pkg::ADDR_GAIN1: st_nxt.gain1 = wdata_i;
        cct_pkg::ADDR_NEAR0: st_nxt.near0 = wdata_i;
        cct_pkg::ADDR_CONT0: st_nxt.cont0 = wdata_i;
        cct_pkg::ADDR_NEAR1: st_nxt.near1 = wdata_i;
        cct_pkg::ADDR_CONT1: st_nxt.cont1 = wdata_i;
        cct_pkg::ADDR_PAUSE: st_nxt.pause = wdata_i;
        default: ;
      endcase
    end
    // flags track the live comparison; read-only, writes ignored
    st_nxt.flags = 8'h00;
    st_nxt.flags[cct_pkg::FLAG_NEAR0] = ch0.near_hit;
    st_nxt.flags[cct_pkg::FLAG_NEAR1] = ch1.near_hit;
    st_nxt.flags[cct_pkg::FLAG_CONT0] = ch0.cont_hit;
    st_nxt.flags[cct_pkg::FLAG_CONT1] = ch1.cont_hit;
    if (rd_en_i) begin
      st_nxt.rvalid = 1'b1;
      unique case (addr_i)
        cct_pkg::ADDR_FLAGS: st_nxt.rdata = st_r.flags;
        cct_pkg::ADDR_TUNE0: st_nxt.rdata = st_r.tune0;
        cct_pkg::ADDR_TUNE1: st_nxt.rdata = st_r.tune1;
        cct_pkg::ADDR_FILT:  st_nxt.rdata = st_r.filt;
        cct_pkg::ADDR_COMP0: st_nxt.rdata = st_r.comp0;
        cct_pkg::ADDR_COMP1: st_nxt.rdata = st_r.comp1;
        cct_pkg::ADDR_GAIN0: st_nxt.rdata = st_r.gain0;
        cct_pkg::ADDR_GAIN1: st_nxt.rdata = st_r.gain1;
        cct_pkg::ADDR_NEAR0: st_nxt.rdata = st_r.near0;
        cct_pkg::ADDR_CONT0: st_nxt.rdata = st_r.cont0;
        cct_pkg::ADDR_NEAR1: st_nxt.rdata = st_r.near1;
        cct_pkg::ADDR_CONT1: st_nxt.rdata = st_r.cont1;
        cct_pkg::ADDR_PAUSE: st_nxt.rdata = st_r.pause;
        default:             st_nxt.rdata = 8'h00;
      endcase
    end
    // pause timer: reload from register, count down in ticks
    if (pause_start_i) begin
      st_nxt.pause_left = st_r.pause;
      st_nxt.tick_cnt = 32'h0000_0000;
    end else if (st_r.pause_left != 8'h00) begin
      if (st_r.tick_cnt == 32'(PAUSE_TICK_CYC - 1)) begin
        st_nxt.tick_cnt = 32'h0000_0000;
        st_nxt.pause_left = st_r.pause_left - 8'h01;
      end else begin
        st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.tune0 <= cct_pkg::RST_TUNE;
      st_r.tune1 <= cct_pkg::RST_TUNE;
      st_r.filt  <= cct_pkg::RST_FILT;
      st_r.pause <= cct_pkg::RST_PAUSE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // decoded configuration
  always_comb begin
    chan0_tuning_base_select_o =
      base_of(st_r.tune0[7:cct_pkg::BASE_LSB]);
    chan1_tuning_base_select_o =
      base_of(st_r.tune1[7:cct_pkg::BASE_LSB]);
    chan0_tuning_target_value_o =
      {st_r.tune0[cct_pkg::TARGET_MSB:0], 5'b00000};
    chan1_tuning_target_value_o =
      {st_r.tune1[cct_pkg::TARGET_MSB:0], 5'b00000};
    cap_divider_en_o = st_r.filt[cct_pkg::DIV_BIT];
    bidir_en_o = st_r.filt[cct_pkg::BIDIR_BIT];
    long_average_weight_o = cct_pkg::LTA_MIN +
      {2'b00, st_r.filt[cct_pkg::LTA_LSB+1:cct_pkg::LTA_LSB]};
    ac_filter_weight_o = cct_pkg::ACF_MIN +
      {1'b0, st_r.filt[1:0]};
    chan0_comp_o = {st_r.gain0[7:cct_pkg::COMPH_LSB], st_r.comp0};
    chan1_comp_o = {st_r.gain1[7:cct_pkg::COMPH_LSB], st_r.comp1};
    chan0_coarse_o =
      st_r.gain0[cct_pkg::COARSE_LSB+1:cct_pkg::COARSE_LSB];
    chan1_coarse_o =
      st_r.gain1[cct_pkg::COARSE_LSB+1:cct_pkg::COARSE_LSB];
    chan0_fine_o = st_r.gain0[3:0];
    chan1_fine_o = st_r.gain1[3:0];
    flags_o = st_r.flags[5:0];
    pause_active_o = st_r.pause_left != 8'h00;
    rdata_o = st_r.rdata;
    rvalid_o = st_r.rvalid;
  end
endmodule
`default_nettype wire

//--- cct_regs_props.sv
`default_nettype none
module cct_regs_props #(
  parameter int PAUSE_TICK_CYC = 4
) (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        rvalid_o,
  input wire logic        pause_start_i,
  input wire logic [7:0]  chan0_tuning_base_select_o,
  input wire logic [10:0] chan1_tuning_target_value_o,
  input wire logic        cap_divider_en_o,
  input wire logic        bidir_en_o,
  input wire logic [1:0]  chan1_coarse_o,
  input wire logic [3:0]  chan1_fine_o,
  input wire logic [5:0]  flags_o,
  input wire logic        pause_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // checks
  localparam logic [7:0] BT [4] = '{8'h4b, 8'h64, 8'h96, 8'hc8};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_base_decode: assert property (
    wr_en_i && addr_i == 8'h43 |=> chan0_tuning_base_select_o ==
    BT[$past(wdata_i[7:6])]) else $error("base select wrong");
  chk_target_scale: assert property (
    wr_en_i && addr_i == 8'h44 |=> chan1_tuning_target_value_o ==
    {$past(wdata_i[5:0]), 5'h00}) else $error("target wrong");
  chk_filter_enables: assert property (
    wr_en_i && addr_i == 8'h45 |=> {cap_divider_en_o, bidir_en_o} ==
    $past(wdata_i[6:5])) else $error("filter enables wrong");
  chk_gain_split: assert property (
    wr_en_i && addr_i == 8'h49 |=> {chan1_coarse_o, chan1_fine_o} ==
    $past(wdata_i[5:0])) else $error("multipliers wrong");
  chk_read_pulse: assert property (
    rvalid_o == $past(rd_en_i)) else $error("read valid wrong");
  chk_unmapped_zero: assert property (
    rd_en_i && !(addr_i inside {8'h11, [8'h43:8'h49], [8'h50:8'h54]})
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_flag_gaps: assert property (
    flags_o[3:2] == 2'h0) else $error("flag gap bits set");
  chk_pause_cause: assert property (
    $rose(pause_active_o) |-> $past(pause_start_i))
    else $error("pause began unasked");
  cover property (rd_en_i && addr_i == 8'h11);
  cover property ($fell(pause_active_o));
  cover property (flags_o[4] && flags_o[1]);
endmodule
bind cct_regs cct_regs_props #(.PAUSE_TICK_CYC(PAUSE_TICK_CYC)) u_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .pause_start_i(pause_start_i),
  .chan0_tuning_base_select_o(chan0_tuning_base_select_o),
  .chan1_tuning_target_value_o(chan1_tuning_target_value_o),
  .cap_divider_en_o(cap_divider_en_o), .bidir_en_o(bidir_en_o),
  .chan1_coarse_o(chan1_coarse_o), .chan1_fine_o(chan1_fine_o),
  .flags_o(flags_o), .pause_active_o(pause_active_o));
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // harness
  localparam logic [7:0] AD [12] = '{8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
    8'h48, 8'h49, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
  localparam logic [7:0] BT [4] = '{8'h4b, 8'h64, 8'h96, 8'hc8};
  logic        clk, rst, wr, rd, ps, ok, cd, bd, pa, rv;
  logic [7:0]  addr, wd, rdat, q, b0, b1, e;
  logic [15:0] a0, c0, a1, c1;
  logic [10:0] t0, t1;
  logic [9:0]  m0, m1;
  logic [3:0]  lw, f0, f1;
  logic [2:0]  aw;
  logic [1:0]  k0, k1;
  logic [5:0]  fl;
  int          err_count, compares, n;
  cct_regs #(.PAUSE_TICK_CYC(4)) uut (.core_clk_i(clk), .rst_i(rst),
    .wr_en_i(wr), .rd_en_i(rd), .addr_i(addr), .wdata_i(wd),
    .rdata_o(rdat), .rvalid_o(rv), .chan0_avg_i(a0), .chan0_cnt_i(c0),
    .chan1_avg_i(a1), .chan1_cnt_i(c1), .pause_start_i(ps),
    .chan0_tuning_base_select_o(b0), .chan0_tuning_target_value_o(t0),
    .chan1_tuning_base_select_o(b1), .chan1_tuning_target_value_o(t1),
    .cap_divider_en_o(cd), .bidir_en_o(bd), .long_average_weight_o(lw),
    .ac_filter_weight_o(aw), .chan0_comp_o(m0), .chan1_comp_o(m1),
    .chan0_coarse_o(k0), .chan0_fine_o(f0), .chan1_coarse_o(k1),
    .chan1_fine_o(f1), .flags_o(fl), .pause_active_o(pa));
  cct_host host (.clk_i(clk), .rdata_i(rdat), .rvalid_i(rv),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q, ok);
    chk(16'(ok), 16'h0001);
    chk(16'(q), 16'(e));
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
  // ======
  // scenarios
  initial begin
    {rst, ps, a0, c0, a1, c1} = {2'b10, 64'h0};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      e = (i < 2) ? 8'h50 : (i == 11) ? 8'h28 : 8'h00;
      rchk(AD[i], e);
    end
    for (int i = 0; i < 12; i++) host.wr(AD[i], 8'hff - 8'(i * 7));
    for (int i = 0; i < 12; i++) begin
      e = (i == 2) ? 8'h61 : 8'hff - 8'(i * 7);
      rchk(AD[i], e);
    end
    chk({6'h0, m0}, 16'h03ea);
    chk({6'h0, m1}, 16'h03e3);
    chk({10'h0, k0, f0}, 16'h001c);
    chk({10'h0, k1, f1}, 16'h0015);
    rchk(8'h30, 8'h00);
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h43, {2'(c), 6'h3f - 6'(c)});
      chk({8'h0, b0}, {8'h0, BT[c]});
      chk({5'h0, t0}, {5'h0, 6'h3f - 6'(c), 5'h00});
      host.wr(8'h44, {2'(3 - c), 6'(c)});
      chk({8'h0, b1}, {8'h0, BT[3 - c]});
      chk({5'h0, t1}, {5'h0, 6'(c), 5'h00});
      host.wr(8'h45, {1'b0, 1'(c), 1'(c >> 1), 1'b0, 2'(c), ~2'(c)});
      chk({14'h0, cd, bd}, {14'h0, 1'(c), 1'(c >> 1)});
      chk({9'h0, lw, aw}, {9'h0, 4'(7 + c), 3'(4 - c)});
    end
    host.wr(8'h45, 8'h00);
    for (int i = 0; i < 4; i++) host.wr(AD[7 + i], 8'h10 << (i & 1));
    {a0, c0, a1, c1} = {16'h0120, 16'h0100, 16'h0100, 16'h0115};
    repeat (2) @(posedge clk) #1;
    chk({10'h0, fl}, 16'h0001);
    host.wr(8'h45, 8'h20);
    a0 = 16'h0121;
    repeat (2) @(posedge clk) #1;
    chk({10'h0, fl}, 16'h0013);
    host.wr(8'h11, 8'h00);
    rchk(8'h11, 8'h13);
    host.wr(8'h54, 8'h02);
    ps = 1'b1;
    @(posedge clk) #1 ps = 1'b0;
    n = 0;
    while (pa === 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    // two ticks of four cycles each
    chk(16'(n), 16'h0008);
    close_out();
  end
endmodule
`default_nettype wire
